// ### rtl/boot_flash_pkg.sv
// Shared constants of the boot flash loader
package boot_flash_pkg;
    // Clocks
    localparam int CLK_HZ           = 20_000_000;
    localparam int LINK_PERIOD_NS   = 80;
    localparam int LINK_HZ          = 1_000_000_000 / LINK_PERIOD_NS;
    // Serial clock rates, nominal
    localparam int SLOW_SCK_HZ      = 1_420_000;
    localparam int FAST_SCK_HZ      = 30_000_000;
    localparam int SYNC_LATENCY     = 3;
    localparam int SLOW_HALF_RAW    = LINK_HZ / (2 * SLOW_SCK_HZ);
    localparam int FAST_HALF_RAW    = LINK_HZ / (2 * FAST_SCK_HZ);
    localparam int SLOW_HALF        = (SLOW_HALF_RAW < 1) ? 1 : SLOW_HALF_RAW;
    localparam int FAST_HALF        = (FAST_HALF_RAW < 1) ? 1 : FAST_HALF_RAW;
    localparam int SLOW_HIGH        = (SLOW_HALF < SYNC_LATENCY) ? SYNC_LATENCY : SLOW_HALF;
    localparam int FAST_HIGH        = (FAST_HALF < SYNC_LATENCY) ? SYNC_LATENCY : FAST_HALF;
    // Chip select deselect time
    localparam int CS_HIGH_NS       = 200;
    localparam int CS_HIGH_CYC      = (CS_HIGH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    // Typical initialization time
    localparam int INIT_TYPICAL_MS  = 500;
    localparam int INIT_TYPICAL_CYC = (CLK_HZ / 1000) * INIT_TYPICAL_MS;
    // Flash addressing
    localparam int ADDR_W           = 24;
    localparam int FLASH_BYTES      = 16 * 1024 * 1024;
    localparam logic [23:0] BOOT_ADDR_RST  = 24'h000000;
    localparam logic [23:0] BOOT_BYTES_RST = 24'h001000;
    // Opcodes
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] READ_STATUS_CMD  = 8'h05;
    localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
    localparam logic [7:0] FAST_READ_CMD    = 8'h0b;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
    localparam logic [7:0] CHIP_ERASE_CMD   = 8'hc7;
    // Status byte layout
    localparam int WRITE_IN_PROGRESS_BIT = 0;
    localparam int WRITE_LATCH_FLAG      = 1;
    localparam int PROTECT_LO_BIT        = 2;
    localparam int PROTECT_HI_BIT        = 6;
    localparam int STATUS_WRITE_LOCK_BIT = 7;
    localparam logic [7:0] STATUS_CLEAR  = 8'h00;
    // Frame byte counts
    localparam logic [2:0] LEN_OPCODE    = 3'h1;
    localparam logic [2:0] LEN_STATUS_WR = 3'h2;
    localparam logic [2:0] LEN_ADDR      = 3'h4;
    localparam logic [2:0] LEN_READ_HDR  = 3'h5;
    localparam logic [23:0] LEN_STATUS_RD = 24'h000001;
    // Buffer
    localparam int FIFO_DEPTH       = 32;
    localparam int FIFO_WIDTH       = 8;
endpackage

// ### rtl/boot_flash_loader.sv
// Boot flash loader: flash link engine, boot sequencer, copy buffer
//
// Functional notes
// R1 - Status line undriven while reset held
// R2 - Status line undriven until boot copy ends
// R3 - Drive status line high during auto-init
// R4 - Drive status line low when init completes
// R5 - No commands or video before init completes
// R6 - Flag init exceeding typical 500 ms
// R7 - Flash addressed with 24-bit byte addresses
// R8 - Start slow serial clock, then go fast
// R9 - Boot from chip select zero; two selects
// R10 - Copy code to program memory, start init
// R11 - Single data line, SPI mode 0
// R12 - Status bit 0 means flash busy
// R13 - Poll write latch bit before writes
// R14 - Zero bits 6..2 removes protection
// R15 - Flash bit 7 locks status writes; the flash model accepts status writes with it set
// R16 - Only one status byte read or written
// R17 - Boot: write enable, poll, clear status
// R18 - New write enable before each erase
// R19 - Poll busy bit clear after writes
`timescale 1ns/10ps

module boot_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Fill side
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    // Drain side
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wrPtr_q;
    logic [PW-1:0]    rdPtr_q;
    logic [PW:0]      count_q;
    wire              push = inValid && inReady;
    wire              pop  = outValid && outReady;

    assign inReady  = (count_q != (PW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem_q[rdPtr_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= push ? PW'((wrPtr_q + 1'b1) % DEPTH) : wrPtr_q;
            rdPtr_q <= pop ? PW'((rdPtr_q + 1'b1) % DEPTH) : rdPtr_q;
            count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // boot_fifo

module boot_flash_loader #(
    parameter logic [23:0] BOOT_ADDR  = boot_flash_pkg::BOOT_ADDR_RST,
    parameter logic [23:0] BOOT_BYTES = boot_flash_pkg::BOOT_BYTES_RST,
    parameter int          INIT_CYC   = boot_flash_pkg::INIT_TYPICAL_CYC,
    parameter int          FIFO_DEPTH = boot_flash_pkg::FIFO_DEPTH
) (
    // Core clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Flash link
    input  wire logic        linkClk,
    output logic             flashSck,
    output logic             flashMosi,
    input  wire logic        flashMiso,
    output logic             flashSelectZeroN,
    output logic             flashSelectOneN,
    // Program memory write port
    output logic             progWrValid,
    output logic      [23:0] progWrAddr,
    output logic      [7:0]  progWrData,
    input  wire logic        progWrReady,
    // Auto-initialization handshake
    output logic             runAutoInit,
    input  wire logic        autoInitDone,
    output logic             hostIrqOut,
    output logic             hostIrqOe,
    output logic             hostReady,
    output logic             initSlow,
    // Erase requests after init
    input  wire logic        eraseReq,
    input  wire logic        eraseChip,
    input  wire logic        eraseSel,
    input  wire logic [23:0] eraseAddr,
    output logic             flashBusy
);
    typedef enum logic [3:0] {
        C_START, C_WRITE_ENABLE_CMD, C_WEL_POLL, C_WRITE_STATUS_CMD, C_BUSY_POLL, C_READ, C_COPY,
        C_INIT, C_READY, C_E_WRITE_ENABLE_CMD, C_E_WEL, C_E_ERASE, C_E_BUSY
    } core_state_t;

    typedef enum logic [2:0] {L_IDLE, L_LOW, L_HIGH, L_ACK, L_GAP} link_state_t;

    function automatic logic [39:0] addrFrame(input logic [7:0] op, input logic [23:0] a);
        addrFrame = {op, a, 8'h00};
    endfunction

    // Core domain state
    core_state_t state_q;
    core_state_t stateD;
    logic        issued_q;
    logic        reqTgl_q;
    logic [39:0] cmdTx_q;
    logic [2:0]  cmdTxBytes_q;
    logic [23:0] cmdRxBytes_q;
    logic        cmdFast_q;
    logic        cmdSel_q;
    logic        fastRate_q;
    logic [7:0]  status_q;
    logic        rxPend_q;
    logic        ackTgl_q;
    logic        doneS1_q, doneS2_q, doneS3_q;
    logic        rxS1_q, rxS2_q, rxS3_q;
    logic        eraseChip_q;
    logic        eraseSel_q;
    logic [23:0] eraseAddr_q;
    logic [31:0] initCnt_q;
    logic        fifoInReady;
    logic        fifoOutValid;
    logic [7:0]  fifoOutData;

    // Link domain state
    link_state_t lstate_q;
    logic        linkRst1_q, linkRst_q;
    logic        misoS1_q, misoS2_q;
    logic        reqS1_q, reqS2_q, reqSeen_q;
    logic        ackS1_q, ackS2_q;
    logic [7:0]  cnt_q;
    logic [2:0]  bitCnt_q;
    logic [39:0] txSh_q;
    logic [2:0]  txLeft_q;
    logic [23:0] rxLeft_q;
    logic [7:0]  rxSh_q;
    logic [7:0]  rxByte_q;
    logic        rxTgl_q;
    logic        doneTgl_q;
    logic        fast_q;

    // Core side decode
    wire doneEv   = doneS2_q ^ doneS3_q;
    wire rxEv     = rxS2_q ^ rxS3_q;
    wire inPoll   = (state_q == C_WEL_POLL) || (state_q == C_BUSY_POLL) ||
                    (state_q == C_E_WEL) || (state_q == C_E_BUSY);
    wire inErase  = (state_q == C_E_WRITE_ENABLE_CMD) || (state_q == C_E_WEL) ||
                    (state_q == C_E_ERASE) || (state_q == C_E_BUSY);
    wire inWren   = (state_q == C_WRITE_ENABLE_CMD) || (state_q == C_E_WRITE_ENABLE_CMD);
    wire cmdState = inPoll || inWren || (state_q == C_WRITE_STATUS_CMD) ||
                    (state_q == C_READ) || (state_q == C_E_ERASE);
    wire issue    = cmdState && !issued_q;
    wire latchSet = status_q[boot_flash_pkg::WRITE_LATCH_FLAG];          // R13
    wire flashBsy = status_q[boot_flash_pkg::WRITE_IN_PROGRESS_BIT];     // R12
    wire copyIdle = !fifoOutValid && !progWrValid && !rxPend_q;
    wire rxToFifo = rxPend_q && fifoInReady;

    // Frame for the command about to be issued
    wire [39:0] issueTx =
        inWren ? {boot_flash_pkg::WRITE_ENABLE_CMD, 32'h0} :                // R17 R18
        inPoll ? {boot_flash_pkg::READ_STATUS_CMD, 32'h0} :
        (state_q == C_WRITE_STATUS_CMD) ?
            {boot_flash_pkg::WRITE_STATUS_CMD, boot_flash_pkg::STATUS_CLEAR, 24'h0} : // R14 R16
        (state_q == C_READ) ? addrFrame(boot_flash_pkg::FAST_READ_CMD, BOOT_ADDR) :  // R7
        eraseChip_q ? {boot_flash_pkg::CHIP_ERASE_CMD, 32'h0} :
        addrFrame(boot_flash_pkg::SECTOR_ERASE_CMD, eraseAddr_q);
    wire [2:0] issueTxBytes =
        inPoll ? boot_flash_pkg::LEN_OPCODE :
        inWren ? boot_flash_pkg::LEN_OPCODE :
        (state_q == C_WRITE_STATUS_CMD) ? boot_flash_pkg::LEN_STATUS_WR :
        (state_q == C_READ) ? boot_flash_pkg::LEN_READ_HDR :
        eraseChip_q ? boot_flash_pkg::LEN_OPCODE : boot_flash_pkg::LEN_ADDR;
    wire [23:0] issueRx =
        inPoll ? boot_flash_pkg::LEN_STATUS_RD :                           // R16
        (state_q == C_READ) ? BOOT_BYTES : 24'h0;

    always_comb begin
        stateD = state_q;
        unique case (state_q)
            C_START:     stateD = C_WRITE_ENABLE_CMD;                                 // R17
            C_WRITE_ENABLE_CMD:      if (doneEv) stateD = C_WEL_POLL;
            C_WEL_POLL:  if (doneEv && latchSet) stateD = C_WRITE_STATUS_CMD;         // R13
            C_WRITE_STATUS_CMD:      if (doneEv) stateD = C_BUSY_POLL;
            C_BUSY_POLL: if (doneEv && !flashBsy) stateD = C_READ;        // R19
            C_READ:      if (doneEv) stateD = C_COPY;
            C_COPY:      if (copyIdle) stateD = C_INIT;                   // R10
            C_INIT:      if (autoInitDone) stateD = C_READY;
            C_READY:     if (eraseReq) stateD = C_E_WRITE_ENABLE_CMD;                 // R18
            C_E_WRITE_ENABLE_CMD:    if (doneEv) stateD = C_E_WEL;
            C_E_WEL:     if (doneEv && latchSet) stateD = C_E_ERASE;      // R13
            C_E_ERASE:   if (doneEv) stateD = C_E_BUSY;
            C_E_BUSY:    if (doneEv && !flashBsy) stateD = C_READY;       // R19
            default:     stateD = C_START;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q  <= C_START;
            issued_q <= 1'b0;
            reqTgl_q <= 1'b0;
        end else begin
            state_q  <= stateD;
            issued_q <= doneEv ? 1'b0 : (issued_q || issue);
            reqTgl_q <= reqTgl_q ^ issue;
        end
    end

    // Command fields stay put while the link works on them
    always_ff @(posedge clk) begin
        if (srst) begin
            cmdTx_q      <= '0;
            cmdTxBytes_q <= '0;
            cmdRxBytes_q <= '0;
            cmdFast_q    <= 1'b0;
            cmdSel_q     <= 1'b0;
            fastRate_q   <= 1'b0;
        end else if (issue) begin
            cmdTx_q      <= issueTx;
            cmdTxBytes_q <= issueTxBytes;
            cmdRxBytes_q <= issueRx;
            cmdFast_q    <= fastRate_q || (state_q == C_READ);            // R8
            cmdSel_q     <= inErase && eraseSel_q;                        // R9
            fastRate_q   <= fastRate_q || (state_q == C_READ);            // R8
        end
    end

    // Received bytes: status in polls, otherwise to the copy buffer
    always_ff @(posedge clk) begin
        if (srst) begin
            status_q <= '0;
            rxPend_q <= 1'b0;
            ackTgl_q <= 1'b0;
        end else begin
            if (rxEv && inPoll) begin
                status_q <= rxByte_q;
            end
            rxPend_q <= (rxEv && !inPoll) || (rxPend_q && !fifoInReady);
            ackTgl_q <= ackTgl_q ^ ((rxEv && inPoll) || rxToFifo);
        end
    end

    // Toggles from the link domain
    always_ff @(posedge clk) begin
        if (srst) begin
            {doneS1_q, doneS2_q, doneS3_q} <= '0;
            {rxS1_q, rxS2_q, rxS3_q}       <= '0;
        end else begin
            {doneS1_q, doneS2_q, doneS3_q} <= {doneTgl_q, doneS1_q, doneS2_q};
            {rxS1_q, rxS2_q, rxS3_q}       <= {rxTgl_q, rxS1_q, rxS2_q};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            eraseChip_q <= 1'b0;
            eraseSel_q  <= 1'b0;
            eraseAddr_q <= '0;
        end else if (state_q == C_READY && eraseReq) begin
            eraseChip_q <= eraseChip;
            eraseSel_q  <= eraseSel;
            eraseAddr_q <= eraseAddr;
        end
    end

    // Boot copy buffer; a stalled memory port fills it and stops the link
    boot_fifo #(
        .WIDTH (boot_flash_pkg::FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .srst     (srst),
        .inValid  (rxPend_q),
        .inData   (rxByte_q),
        .inReady  (fifoInReady),
        .outValid (fifoOutValid),
        .outData  (fifoOutData),
        .outReady (!progWrValid || progWrReady)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            progWrValid <= 1'b0;
            progWrData  <= '0;
            progWrAddr  <= '0;
        end else if (fifoOutValid && (!progWrValid || progWrReady)) begin
            progWrValid <= 1'b1;                                          // R10
            progWrData  <= fifoOutData;
            progWrAddr  <= progWrValid ? progWrAddr + 24'h1 : progWrAddr;
        end else if (progWrReady) begin
            progWrValid <= 1'b0;
            progWrAddr  <= progWrValid ? progWrAddr + 24'h1 : progWrAddr;
        end
    end

    // Status line and host readiness
    always_ff @(posedge clk) begin
        if (srst) begin
            hostIrqOe   <= 1'b0;                                          // R1
            hostIrqOut  <= 1'b0;
            hostReady   <= 1'b0;
            runAutoInit <= 1'b0;
            flashBusy   <= 1'b1;
        end else begin
            hostIrqOe   <= (state_q == C_INIT) || (hostReady);            // R2
            hostIrqOut  <= (state_q == C_INIT);                           // R3 R4
            hostReady   <= hostReady || (state_q == C_INIT && autoInitDone); // R5
            runAutoInit <= (state_q == C_INIT);                           // R10
            flashBusy   <= (state_q != C_READY);
        end
    end

    // Typical init time is a soft limit, so only a flag
    always_ff @(posedge clk) begin
        if (srst) begin
            initCnt_q <= '0;
            initSlow  <= 1'b0;
        end else if (!hostReady) begin
            initCnt_q <= (initCnt_q == 32'(INIT_CYC)) ? initCnt_q : initCnt_q + 32'h1;
            initSlow  <= initSlow || (initCnt_q == 32'(INIT_CYC));         // R6
        end
    end

    // Link domain: reset and input synchronisers
    always_ff @(posedge linkClk) begin
        linkRst1_q <= srst;
        linkRst_q  <= linkRst1_q;
        misoS1_q   <= flashMiso;
        misoS2_q   <= misoS1_q;
        reqS1_q    <= reqTgl_q;
        reqS2_q    <= reqS1_q;
        ackS1_q    <= ackTgl_q;
        ackS2_q    <= ackS1_q;
    end

    wire [7:0] halfCyc = fast_q ? 8'(boot_flash_pkg::FAST_HALF) : 8'(boot_flash_pkg::SLOW_HALF);
    wire [7:0] highCyc = fast_q ? 8'(boot_flash_pkg::FAST_HIGH) : 8'(boot_flash_pkg::SLOW_HIGH);
    wire [7:0] firstHalf = cmdFast_q ? 8'(boot_flash_pkg::FAST_HALF) :
                                       8'(boot_flash_pkg::SLOW_HALF);
    wire [7:0] rxNext  = {rxSh_q[6:0], misoS2_q};
    wire       byteEnd = (bitCnt_q == 3'h7);
    wire       lastTx  = (txLeft_q == 3'h1) && (rxLeft_q == 24'h0);

    // High phase covers the miso synchroniser delay, so fast rate is capped
    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            lstate_q         <= L_IDLE;
            flashSck         <= 1'b0;                                     // R11
            flashMosi        <= 1'b0;
            flashSelectZeroN <= 1'b1;
            flashSelectOneN  <= 1'b1;
            reqSeen_q        <= 1'b0;
            rxTgl_q          <= 1'b0;
            doneTgl_q        <= 1'b0;
            cnt_q            <= '0;
            bitCnt_q         <= '0;
            txSh_q           <= '0;
            txLeft_q         <= '0;
            rxLeft_q         <= '0;
            rxSh_q           <= '0;
            rxByte_q         <= '0;
            fast_q           <= 1'b0;
        end else begin
            unique case (lstate_q)
                L_IDLE: if (reqS2_q != reqSeen_q) begin
                    reqSeen_q        <= reqS2_q;
                    txSh_q           <= cmdTx_q;
                    txLeft_q         <= cmdTxBytes_q;
                    rxLeft_q         <= cmdRxBytes_q;
                    fast_q           <= cmdFast_q;                        // R8
                    flashSelectZeroN <= cmdSel_q;                         // R9
                    flashSelectOneN  <= !cmdSel_q;
                    flashMosi        <= cmdTx_q[39];                      // R11
                    bitCnt_q         <= '0;
                    cnt_q            <= firstHalf - 8'h1;
                    lstate_q         <= L_LOW;
                end
                L_LOW: if (cnt_q == 8'h0) begin
                    flashSck <= 1'b1;                                     // R11
                    cnt_q    <= highCyc - 8'h1;
                    lstate_q <= L_HIGH;
                end else begin
                    cnt_q <= cnt_q - 8'h1;
                end
                L_HIGH: if (cnt_q == 8'h0) begin
                    flashSck  <= 1'b0;
                    rxSh_q    <= rxNext;                                  // R11
                    txSh_q    <= {txSh_q[38:0], 1'b0};
                    flashMosi <= txSh_q[38];
                    bitCnt_q  <= bitCnt_q + 3'h1;
                    cnt_q     <= halfCyc - 8'h1;
                    if (byteEnd && txLeft_q != 3'h0) begin
                        txLeft_q <= txLeft_q - 3'h1;
                        lstate_q <= lastTx ? L_GAP : L_LOW;
                        if (lastTx) begin
                            cnt_q <= 8'(boot_flash_pkg::CS_HIGH_CYC) - 8'h1;
                        end
                    end else if (byteEnd) begin
                        rxByte_q <= rxNext;
                        rxTgl_q  <= !rxTgl_q;
                        rxLeft_q <= rxLeft_q - 24'h1;
                        lstate_q <= L_ACK;
                    end else begin
                        lstate_q <= L_LOW;
                    end
                end else begin
                    cnt_q <= cnt_q - 8'h1;
                end
                L_ACK: if (ackS2_q == rxTgl_q) begin
                    lstate_q <= (rxLeft_q == 24'h0) ? L_GAP : L_LOW;
                    if (rxLeft_q == 24'h0) begin
                        cnt_q <= 8'(boot_flash_pkg::CS_HIGH_CYC) - 8'h1;
                    end
                end
                L_GAP: begin
                    flashSelectZeroN <= 1'b1;
                    flashSelectOneN  <= 1'b1;
                    if (cnt_q == 8'h0) begin
                        doneTgl_q <= !doneTgl_q;
                        lstate_q  <= L_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h1;
                    end
                end
                default: lstate_q <= L_IDLE;
            endcase
        end
    end
endmodule // boot_flash_loader

// ### tb/boot_flash_props.sv
// Port checker for the boot flash loader
`timescale 1ns/10ps
module boot_flash_props (
    // Clocks and reset
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        linkClk,
    // Flash link
    input wire logic        flashSck,
    input wire logic        flashMosi,
    input wire logic        flashSelectZeroN,
    input wire logic        flashSelectOneN,
    // Copy and status
    input wire logic        progWrValid,
    input wire logic        progWrReady,
    input wire logic [23:0] progWrAddr,
    input wire logic        hostIrqOut,
    input wire logic        hostIrqOe,
    input wire logic        hostReady,
    input wire logic        flashBusy
);
    property p_rel; @(posedge clk) disable iff (srst) $fell(srst) |-> !hostIrqOe; endproperty
    a_rel: assert property (p_rel) else $error("driven at reset exit");
    property p_copy; @(posedge clk) disable iff (srst) progWrValid |-> !hostIrqOe; endproperty
    a_copy: assert property (p_copy) else $error("driven in copy");
    property p_auto; @(posedge clk) disable iff (srst) hostIrqOe && !hostReady |-> hostIrqOut;
    endproperty
    a_auto: assert property (p_auto) else $error("low before ready");
    property p_low; @(posedge clk) disable iff (srst) hostIrqOe && !hostIrqOut |-> hostReady;
    endproperty
    a_low: assert property (p_low) else $error("low without ready");
    property p_busy; @(posedge clk) disable iff (srst) !hostReady |-> flashBusy; endproperty
    a_busy: assert property (p_busy) else $error("idle before init");
    property p_hold; @(posedge clk) disable iff (srst)
        progWrValid && !progWrReady |=> progWrValid && $stable(progWrAddr); endproperty
    a_hold: assert property (p_hold) else $error("stalled write dropped");
    property p_order; @(posedge clk) disable iff (srst) progWrValid && progWrReady
        |=> !progWrValid || progWrAddr == $past(progWrAddr) + 24'h000001; endproperty
    a_order: assert property (p_order) else $error("address skipped");
    property p_sel; @(posedge linkClk) disable iff (srst) !hostReady |-> flashSelectOneN;
    endproperty
    a_sel: assert property (p_sel) else $error("select one in boot");
    property p_idle; @(posedge linkClk) disable iff (srst)
        flashSelectZeroN && flashSelectOneN |-> !flashSck; endproperty
    a_idle: assert property (p_idle) else $error("clock outside frame");
    property p_mosi; @(posedge linkClk) disable iff (srst)
        flashSck [*2] |-> $stable(flashMosi); endproperty
    a_mosi: assert property (p_mosi) else $error("data moved, clock high");
endmodule // boot_flash_props
bind boot_flash_loader boot_flash_props i_boot_flash_props (.*);

// ### tb/flash_model.sv
// Serial flash model, mode 0, one data line each way
`timescale 1ns/10ps
module flash_model (
    // Link pins
    input  wire logic sck,
    input  wire logic selN,
    input  wire logic mosi,
    output logic      miso
);
    // Lock bit and protection bits 4..2 start set, as shipped; bits 6 and 5 start clear
    logic [7:0]  st = 8'h9c, wrStatus = 8'hff, op, eraseOp, rx, tx;
    logic [23:0] addr;
    logic        write_latch_flag = 1'b0;
    int          nBit, nByte, busy = 0, badErase = 0, eraseOps = 0;
    initial miso = 1'b0;
    always @(negedge selN) begin
        nBit = 0;
        nByte = 0;
    end
    always @(posedge sck) if (!selN) begin
        rx = {rx[6:0], mosi};
        nBit++;
        if (nBit % 8 == 0) begin
            nByte++;
            if (nByte == 1) op = rx;
            if (nByte > 1 && nByte < 5 && (op == 8'h0b || op == 8'h20)) addr = {addr[15:0], rx};
            if (op == 8'h01 && nByte == 2) wrStatus = rx;
            tx = (op == 8'h05) ? {st[7:2], write_latch_flag, 1'(busy > 0)} : addr[7:0] ^ 8'h5a;
            if (op == 8'h0b && nByte > 4) addr++;
        end
    end
    // Edge driven, so either clock rate is answered
    always @(negedge sck) if (!selN) begin
        miso = tx[7];
        tx = tx << 1;
    end
    // No pull on the data line: show the inverse once released
    always @(posedge selN) begin
        miso = ~miso;
        if (op == 8'h06) write_latch_flag = 1'b1;
        if (op == 8'h01 && write_latch_flag) begin
            st = wrStatus;
            write_latch_flag = 1'b0;
            busy = 2;
        end
        if (op == 8'h20 || op == 8'hc7) begin
            badErase += int'(!write_latch_flag);
            eraseOps++;
            eraseOp = op;
            write_latch_flag = 1'b0;
            busy = 3;
        end
        if (op == 8'h05 && busy > 0) busy--;
    end
endmodule // flash_model

// ### tb/boot_flash_loader_tb.sv
// Self-checking bench for the boot flash loader
`timescale 1ns/10ps
module boot_flash_loader_tb;
    localparam logic [23:0] NBYTES = 24'h000030;
    localparam int          INITC  = 9000;
    logic        clk = 1'b0, linkClk = 1'b0, srst = 1'b1, progWrReady = 1'b0;
    logic        autoInitDone = 1'b0, eraseReq = 1'b0, eraseChip = 1'b0, eraseSel = 1'b0;
    logic [23:0] eraseAddr = 24'h000000, progWrAddr;
    logic [7:0]  progWrData;
    logic        flashSck, flashMosi, flashMiso, flashSelectZeroN, flashSelectOneN;
    logic        progWrValid, runAutoInit, hostIrqOut, hostIrqOe, hostReady, initSlow, flashBusy;
    int          errors = 0, samples_checked = 0, hiLen = 0, firstHi = 0, lastHi = 0, sel1 = 0;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
    always #25 clk = ~clk;
    initial begin
        #13;
        forever #40 linkClk = ~linkClk;
    end
    boot_flash_loader #(.BOOT_BYTES(NBYTES), .INIT_CYC(INITC)) i_boot_flash_loader (.*);
    flash_model i_flash_model (.sck(flashSck), .selN(flashSelectZeroN & flashSelectOneN),
        .mosi(flashMosi), .miso(flashMiso));
    // Clock high time per bit tells the slow rate from the fast
    always @(posedge linkClk) begin
        if (flashSck) hiLen <= hiLen + 1;
        else if (hiLen > 0) begin
            firstHi <= (firstHi == 0) ? hiLen : firstHi;
            lastHi <= hiLen;
            hiLen <= 0;
        end
    end
    always @(negedge flashSelectOneN) sel1++;
    // Stall the copy long enough to fill the buffer and pause the link
    task automatic bootRun(input int stall, input int doneAt, input logic slowExp);
        int n, cyc;
        n = 0;
        {srst, autoInitDone, progWrReady} = 3'b100;
        repeat (5) @(negedge clk);
        `CHK({hostIrqOe, hostReady, flashBusy}, 3'b001)
        srst = 1'b0;
        for (cyc = 0; cyc < 40000 && !runAutoInit; cyc++) begin
            @(negedge clk);
            progWrReady = (cyc >= stall);
            if (progWrValid && progWrReady) begin
                `CHK(progWrAddr, 24'(n))
                `CHK(progWrData, 8'(n) ^ 8'h5a)
                n++;
            end
        end
        `CHK(24'(n), NBYTES)
        `CHK(lastHi, boot_flash_pkg::FAST_HIGH)
        repeat (3) @(negedge clk);
        `CHK({hostIrqOe, hostIrqOut, hostReady}, 3'b110)
        repeat (doneAt) @(negedge clk);
        autoInitDone = 1'b1;
        for (cyc = 0; cyc < 10 && !hostReady; cyc++) @(negedge clk);
        @(negedge clk);
        `CHK({hostIrqOe, hostIrqOut, hostReady, flashBusy}, 4'b1010)
        `CHK(initSlow, slowExp)
        `CHK(i_flash_model.st, 8'h00)
        `CHK(i_flash_model.wrStatus, boot_flash_pkg::STATUS_CLEAR)
    endtask
    task automatic erase(input logic chip, input logic sel);
        int i, e, s;
        e = i_flash_model.eraseOps;
        s = sel1;
        {eraseChip, eraseSel, eraseReq, eraseAddr} = {chip, sel, 1'b1, 24'h012345};
        @(negedge clk);
        eraseReq = 1'b0;
        for (i = 0; i < 3 && !flashBusy; i++) @(negedge clk);
        `CHK(flashBusy, 1'b1)
        for (i = 0; i < 20000 && flashBusy; i++) @(negedge clk);
        `CHK(i_flash_model.eraseOp, chip ? 8'hc7 : 8'h20)
        `CHK(i_flash_model.eraseOps, e + 1)
        `CHK(i_flash_model.busy + i_flash_model.badErase, 0)
        `CHK(sel1 > s, sel)
        if (!chip) `CHK(i_flash_model.addr, 24'h012345)
    endtask
    task automatic test_done();
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        bootRun(4000, 10, 1'b0);
        `CHK(firstHi, boot_flash_pkg::SLOW_HIGH)
        erase(1'b0, 1'b1);
        erase(1'b1, 1'b0);
        bootRun(0, INITC, 1'b1);
        test_done();
    end
    // About three times the expected run
    initial begin
        #(60000 * 50);
        errors++;
        test_done();
    end
endmodule // boot_flash_loader_tb
